// *** logic/aax_pkg.sv ***
// Package: constants and types for the accumulator add/and/xor execute block
`default_nettype none
package aax_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int          INSN_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam int          OSC_PER_CYC   = 4;
  localparam logic [1:0]  PHASE_LAST    = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          DEST_BIT      = 7;
  localparam int          OPC_HI        = 13;
  localparam int          OPC_LO        = 8;

  // ----------------------------------------------------------------
  // Opcode patterns (bits 13..8)
  // ----------------------------------------------------------------
  localparam logic [5:0]  OPC_ADD_LIT   = 6'h3e;
  localparam logic [5:0]  OPC_ADD_LIT_M = 6'h3e;
  localparam logic [5:0]  OPC_AND_LIT   = 6'h39;
  localparam logic [5:0]  OPC_XOR_LIT   = 6'h3a;
  localparam logic [5:0]  OPC_ADD_FILE  = 6'h07;
  localparam logic [5:0]  OPC_AND_FILE  = 6'h05;
  localparam logic [5:0]  OPC_XOR_FILE  = 6'h06;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RST       = 8'h00;

  // ----------------------------------------------------------------
  // Operation kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AAX_OP_NONE,
    AAX_OP_ADD,
    AAX_OP_AND,
    AAX_OP_XOR
  } aax_op_e;

endpackage
`default_nettype wire

// *** logic/aax_file_if.sv ***
// Interface: file-register access between the execute core and file store
`timescale 1ns/1ps
`default_nettype none
interface aax_file_if;
  import aax_pkg::*;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  logic              we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  modport core  (output raddr, input rdata, output we, output waddr, output wdata);
  modport store (input raddr, output rdata, input we, input waddr, input wdata);
endinterface
`default_nettype wire

// *** logic/aax_file_mem.sv ***
// Module: file-register store with registered read data
`timescale 1ns/1ps
`default_nettype none
module aax_file_mem
  import aax_pkg::*;
#(
  parameter int DEPTH = 128
) (
  // Clock and reset
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  // Access port
  aax_file_if.store  fif
);

  if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_depth_chk
    $error("DEPTH out of range");
  end

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rdata_q;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (fif.we) begin
      mem_q[fif.waddr] <= fif.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[fif.raddr];
    end
  end

  assign fif.rdata = rdata_q;

endmodule
`default_nettype wire

// *** logic/aax_exec.sv ***
// Module: execute logic for add, and, xor on accumulator with literal or file
// Function
// - Add literal into accumulator, flags C DC Z
// - AND literal into accumulator, zero flag only
// - XOR literal into accumulator, zero flag only
// - Add accumulator and file, flags C DC Z
// - AND accumulator with file, zero only
// - XOR accumulator with file, opcode 0110
// - Destination bit picks accumulator or file
// - One instruction cycle of four clocks
`timescale 1ns/1ps
`default_nettype none
module aax_exec
  import aax_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // Instruction input
  input  wire logic              insn_valid_i,
  input  wire logic [INSN_W-1:0] insn_i,
  // Accumulator and flags
  output logic [DATA_W-1:0]      acc_o,
  output logic                   carry_flag_o,
  output logic                   half_carry_flag_o,
  output logic                   zero_flag_o,
  // Status
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   illegal_o
);

  if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << ADDR_W)) begin : g_depth_chk
    $error("FILE_DEPTH out of range");
  end

  typedef struct packed {
    logic [1:0]        phase;
    logic              busy;
    aax_op_e           op;
    logic              use_file;
    logic              dest_file;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] acc;
    logic              c;
    logic              dc;
    logic              z;
    logic              done;
    logic              illegal;
  } aax_state_s;

  aax_state_s st_q;
  aax_state_s st_d;

  aax_file_if fif ();

  aax_file_mem #(
    .DEPTH (FILE_DEPTH)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .fif       (fif)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W:0] add9(input logic [DATA_W-1:0] a,
                                           input logic [DATA_W-1:0] b);
    add9 = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic [4:0] add_low(input logic [3:0] a, input logic [3:0] b);
    add_low = {1'b0, a} + {1'b0, b};
  endfunction

  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0]   sum;
  logic [4:0]        low;
  logic              last;
  logic [5:0]        opc;

  assign opc  = insn_i[OPC_HI:OPC_LO];
  assign last = st_q.busy && (st_q.phase == PHASE_LAST);

  // ----------------------------------------------------------------
  // Datapath and sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    opnd      = st_q.use_file ? fif.rdata : st_q.lit;
    sum       = add9(st_q.acc, opnd);
    low       = add_low(st_q.acc[3:0], opnd[3:0]);
    res       = '0;
    unique case (st_q.op)
      AAX_OP_ADD: res = sum[DATA_W-1:0];
      AAX_OP_AND: res = st_q.acc & opnd;
      AAX_OP_XOR: res = st_q.acc ^ opnd;
      default:    res = '0;
    endcase

    if (!st_q.busy && insn_valid_i) begin
      st_d.busy      = 1'b1;
      st_d.phase     = '0;
      st_d.illegal   = 1'b0;
      st_d.dest_file = insn_i[DEST_BIT];
      st_d.addr      = insn_i[ADDR_W-1:0];
      st_d.lit       = insn_i[DATA_W-1:0];
      st_d.use_file  = 1'b0;
      if ((opc & OPC_ADD_LIT_M) == OPC_ADD_LIT) begin
        st_d.op = AAX_OP_ADD;
      end else if (opc == OPC_AND_LIT) begin
        st_d.op = AAX_OP_AND;
      end else if (opc == OPC_XOR_LIT) begin
        st_d.op = AAX_OP_XOR;
      end else if (opc == OPC_ADD_FILE) begin
        st_d.op       = AAX_OP_ADD;
        st_d.use_file = 1'b1;
      end else if (opc == OPC_AND_FILE) begin
        st_d.op       = AAX_OP_AND;
        st_d.use_file = 1'b1;
      end else if (opc == OPC_XOR_FILE) begin
        st_d.op       = AAX_OP_XOR;
        st_d.use_file = 1'b1;
      end else begin
        st_d.op      = AAX_OP_NONE;
        st_d.illegal = 1'b1;
      end
    end else if (st_q.busy) begin
      st_d.phase = st_q.phase + 2'h1;
      if (last) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
        if (st_q.op != AAX_OP_NONE) begin
          if (!(st_q.use_file && st_q.dest_file)) begin
            st_d.acc = res;
          end
          st_d.z = (res == '0);
          if (st_q.op == AAX_OP_ADD) begin
            st_d.c  = sum[DATA_W];
            st_d.dc = low[4];
          end
        end
      end
    end
  end

  assign fif.raddr = st_q.addr;
  assign fif.we    = last && st_q.use_file && st_q.dest_file && (st_q.op != AAX_OP_NONE);
  assign fif.waddr = st_q.addr;
  assign fif.wdata = res;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q         <= '0;
      st_q.op      <= AAX_OP_NONE;
      st_q.acc     <= ACC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign acc_o             = st_q.acc;
  assign carry_flag_o      = st_q.c;
  assign half_carry_flag_o = st_q.dc;
  assign zero_flag_o       = st_q.z;
  assign busy_o            = st_q.busy;
  assign done_o            = st_q.done;
  assign illegal_o         = st_q.illegal;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Four clocks per instruction
  cycle_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_o && insn_valid_i) |=> busy_o [*4] ##1 (!busy_o && done_o))
    else $error("instruction cycle not four clocks");

  zero_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (last && st_q.op != AAX_OP_NONE) |=> (zero_flag_o == ($past(res) == 8'h00)))
    else $error("zero flag wrong");

  add_lit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (last && st_q.op == AAX_OP_ADD && !st_q.use_file) |=>
      ({carry_flag_o, acc_o} == ({1'b0, $past(st_q.acc)} + {1'b0, $past(st_q.lit)})))
    else $error("add literal result wrong");

  and_lit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (last && st_q.op == AAX_OP_AND && !st_q.use_file) |=>
      (acc_o == ($past(st_q.acc) & $past(st_q.lit))) && $stable(carry_flag_o))
    else $error("and literal wrong");

  xor_lit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (last && st_q.op == AAX_OP_XOR && !st_q.use_file) |=>
      (acc_o == ($past(st_q.acc) ^ $past(st_q.lit))) && $stable(half_carry_flag_o))
    else $error("xor literal wrong");

  add_file_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (last && st_q.op == AAX_OP_ADD && st_q.use_file) |=>
      (half_carry_flag_o ==
        (({1'b0, $past(st_q.acc[3:0])} + {1'b0, $past(fif.rdata[3:0])}) > 5'h0f)))
    else $error("add file half carry wrong");

  dest_file_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fif.we |=> $stable(acc_o))
    else $error("file destination altered accumulator");

  and_file_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (fif.we && st_q.op == AAX_OP_AND) |->
      (fif.wdata == (st_q.acc & fif.rdata)) ##1
      ($stable(carry_flag_o) && $stable(half_carry_flag_o)))
    else $error("and file result wrong");

  xor_file_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (fif.we && st_q.op == AAX_OP_XOR) |->
      (fif.wdata == (st_q.acc ^ fif.rdata)) ##1
      ($stable(carry_flag_o) && $stable(half_carry_flag_o)))
    else $error("xor file result wrong");

  addr_field_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_o && insn_valid_i) |=> (fif.raddr == $past(insn_i[6:0])))
    else $error("file address field wrong");

endmodule
`default_nettype wire

// *** test/aax_fetch_model.sv ***
// Fetch-side model: offers instruction words to the execute block
`timescale 1ns/1ps
`default_nettype none
module aax_fetch_model
  import aax_pkg::*;
(
  // Request from the bench
  input  wire logic              req_i,
  input  wire logic [INSN_W-1:0] word_i,
  // Instruction port
  output logic                   insn_valid_o,
  output logic [INSN_W-1:0]      insn_o
);
  logic [INSN_W-1:0] last_w = '0;
  // Word held while offered, inverse of last word once released
  always_comb begin
    insn_valid_o = req_i;
    insn_o       = req_i ? word_i : ~last_w;
  end
  always @(req_i or word_i) begin
    if (req_i) last_w = word_i;
  end
endmodule
`default_nettype wire

// *** test/tb_aax_exec.sv ***
// Testbench: corner and random instructions against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_aax_exec;
  import aax_pkg::*;
  logic              clk;
  logic              rst;
  logic              req;
  logic [INSN_W-1:0] word;
  logic              vld;
  logic [INSN_W-1:0] insn;
  logic [DATA_W-1:0] acc;
  logic              cf, hf, zf, busy, done, ill;
  int                fail_count = 0;
  int                samples_checked = 0;
  int                seed = 90876;
  logic [DATA_W-1:0] m_acc;
  logic [DATA_W-1:0] m_file [128];
  logic              m_c, m_h, m_z, m_ill;
  logic [6:0]        a;
  logic [2:0]        k;
  logic [5:0]        opc_tab [8] = '{6'h3e, 6'h3f, 6'h39, 6'h3a, 6'h07, 6'h05, 6'h06, 6'h38};
  logic [13:0]       corner [11] = '{14'h3900, 14'h3a10, 14'h3e15, 14'h3fdb, 14'h3aa3,
                                     14'h395f, 14'h3ab6, 14'h3aaf, 14'h077f, 14'h0000, 14'h3800};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  aax_exec dut_u (
    .ref_clk_i(clk), .rst_i(rst), .insn_valid_i(vld), .insn_i(insn), .acc_o(acc),
    .carry_flag_o(cf), .half_carry_flag_o(hf), .zero_flag_o(zf), .busy_o(busy),
    .done_o(done), .illegal_o(ill));

  aax_fetch_model fm_u (.req_i(req), .word_i(word), .insn_valid_o(vld), .insn_o(insn));

  // --------------------------------------------------------------
  // Checking and expectation
  // --------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic void predict(input logic [INSN_W-1:0] w);
    logic [5:0]        op;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] r;
    logic [8:0]        s;
    op = w[OPC_HI:OPC_LO];
    b = (op[5:4] == 2'h3) ? w[7:0] : m_file[w[6:0]];
    s = {1'b0, m_acc} + {1'b0, b};
    m_ill = 1'b0;
    if ({op[5:1], 1'b0} == OPC_ADD_LIT || op == OPC_ADD_FILE) begin
      r = s[7:0];
      m_c = s[8];
      m_h = ({1'b0, m_acc[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
    end else if (op == OPC_AND_LIT || op == OPC_AND_FILE) begin
      r = m_acc & b;
    end else if (op == OPC_XOR_LIT || op == OPC_XOR_FILE) begin
      r = m_acc ^ b;
    end else begin
      m_ill = 1'b1;
      return;
    end
    m_z = (r == 8'h00);
    if (op[5:4] == 2'h0 && w[DEST_BIT]) m_file[w[6:0]] = r;
    else m_acc = r;
  endfunction

  // Offer one word, hold junk while busy, check timing and results
  task automatic run(input logic [INSN_W-1:0] w);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("busy_wait", 8'(busy), 8'h00);
    predict(w);
    req = 1'b1;
    word = w;
    @(posedge clk);
    #1;
    word = 14'($random(seed));
    for (int i = 1; i <= OSC_PER_CYC; i++) begin
      check("busy", 8'(busy), 8'h01);
      check("done", 8'(done), 8'h00);
      if (i == OSC_PER_CYC - 1) req = 1'b0;
      @(posedge clk);
      #1;
    end
    check("busy", 8'(busy), 8'h00);
    check("done", 8'(done), 8'h01);
    check("illegal", 8'(ill), 8'(m_ill));
    check("acc", acc, m_acc);
    check("carry", 8'(cf), 8'(m_c));
    check("half_carry", 8'(hf), 8'(m_h));
    check("zero", 8'(zf), 8'(m_z));
    @(posedge clk);
    #1;
    check("done", 8'(done), 8'h00);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = 1'b0;
    word = '0;
    m_acc = ACC_RST;
    m_c = 1'b0;
    m_h = 1'b0;
    m_z = 1'b0;
    foreach (m_file[i]) m_file[i] = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    check("acc", acc, ACC_RST);
    check("flags", {5'h00, cf, hf, zf}, 8'h00);
    check("busy", {6'h00, busy, done}, 8'h00);
    for (int i = 0; i < 9; i++) begin
      a = (i == 8) ? 7'h7f : 7'(i);
      run({OPC_AND_LIT, 8'h00});
      run({OPC_AND_FILE, 1'b1, a});
      run({OPC_XOR_LIT, 8'($random(seed))});
      run({OPC_XOR_FILE, 1'b1, a});
    end
    foreach (corner[i]) run(corner[i]);
    // Reset in mid-run clears accumulator, flags and status, keeps the file store
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    m_acc = ACC_RST;
    m_c = 1'b0;
    m_h = 1'b0;
    m_z = 1'b0;
    check("acc", acc, ACC_RST);
    check("flags", {5'h00, cf, hf, zf}, 8'h00);
    check("status", {5'h00, busy, done, ill}, 8'h00);
    repeat (300) begin
      k = 3'($random(seed));
      a = ($random(seed) & 1) ? 7'h7f : 7'($random(seed) & 7);
      run({opc_tab[k], opc_tab[k][5] ? 8'($random(seed)) : {1'($random(seed)), a}});
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
